//--- rtl/adcc_params.svh
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

`define ADCC_ADDR_CFG      8'hbc
`define ADCC_ADDR_CTL      8'he8

`define ADCC_CTL_EN        7
`define ADCC_CTL_BURST     6
`define ADCC_CTL_DONE      5
`define ADCC_CTL_BUSY      4
`define ADCC_CTL_WIN       3
`define ADCC_CTL_SRC_HI    2
`define ADCC_CTL_SRC_LO    0

`define ADCC_CFG_DIV_HI    7
`define ADCC_CFG_DIV_LO    3
`define ADCC_CFG_EIGHT     2
`define ADCC_CFG_DTRACK    1
`define ADCC_CFG_GAIN      0

`define ADCC_CTL_RESET     8'h00
`define ADCC_CFG_RESET     8'hf8

`define ADCC_SRC_SW        3'h0
`define ADCC_SRC_T0        3'h1
`define ADCC_SRC_T2        3'h2
`define ADCC_SRC_T3        3'h3

`define ADCC_TRACK_CLKS    4'h3
`define ADCC_CONV_CLKS10   4'ha
`define ADCC_CONV_CLKS8    4'h8
`define ADCC_CNT_ONE       4'h1
`define ADCC_RPT_ONE       7'h01

`endif

//--- rtl/adcc_pkg.sv
package adcc_pkg;
    // Gray sequence idle -> track -> convert -> finish -> idle
    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_track = 2'b01,
        st_conv  = 2'b11,
        st_fin   = 2'b10
    } adcc_state_t;
endpackage

//--- rtl/adcc_sar_div.sv
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_sar_div (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Control
    input  wire logic       src_tick,
    input  wire logic       restart,
    input  wire logic [4:0] divide,
    // SAR clock enable
    output logic            sar_tick
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;

    // Counting source ticks, one SAR tick every divide+1 of them
    always_comb begin
        cnt_d = cnt_q;
        if (restart) begin
            cnt_d = 5'h00;
        end else if (src_tick) begin
            if (cnt_q >= divide) begin
                cnt_d = 5'h00;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign sar_tick = src_tick && !restart && (cnt_q >= divide);
endmodule

//--- rtl/adcc_top.sv
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_top (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Special function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr_en,
    input  wire logic        sfr_rd_en,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // Start sources and oscillator
    input  wire logic        timer0_overflow,
    input  wire logic        timer2_overflow,
    input  wire logic        timer3_overflow,
    input  wire logic        external_convert_strobe,
    input  wire logic        lp_osc_tick,
    // Converter side
    input  wire logic [9:0]  sample_data,
    input  wire logic [6:0]  burst_repeat,
    input  wire logic [15:0] upper_threshold,
    input  wire logic [15:0] lower_threshold,
    output logic             converter_powered,
    output logic             tracking,
    output logic             converting,
    output logic             gain_select,
    output logic             eight_bit_mode,
    output logic      [7:0]  result_high,
    output logic      [7:0]  result_low
);
    logic [7:0] ctl_q, ctl_d, cfg_q, cfg_d, rdata_q, rdata_d;
    logic [7:0] res_hi_q, res_hi_d, res_lo_q, res_lo_d;
    logic [3:0] cnt_q, cnt_d;
    logic [6:0] left_q, left_d;
    logic       strobe_q;
    adcc_pkg::adcc_state_t st_q, st_d;

    logic       wr_ctl, wr_cfg, enable, burst, dtrack, eight;
    logic       src_ev, start, sar_tick, fin, in_window;
    logic [2:0] src;
    logic [3:0] conv_len;
    logic [6:0] rpt;
    logic [15:0] result;

    assign wr_ctl = sfr_wr_en && (sfr_addr == `ADCC_ADDR_CTL);
    assign wr_cfg = sfr_wr_en && (sfr_addr == `ADCC_ADDR_CFG);
    assign enable = ctl_q[`ADCC_CTL_EN];
    assign burst  = ctl_q[`ADCC_CTL_BURST];
    assign src    = ctl_q[`ADCC_CTL_SRC_HI:`ADCC_CTL_SRC_LO];
    assign dtrack = cfg_q[`ADCC_CFG_DTRACK];
    assign eight  = cfg_q[`ADCC_CFG_EIGHT];
    assign conv_len = eight ? `ADCC_CONV_CLKS8 : `ADCC_CONV_CLKS10;
    // A repeat count of zero would wrap to 128 conversions, so it runs as one
    assign rpt = (burst_repeat == 7'h00) ? `ADCC_RPT_ONE : burst_repeat;
    assign result = {res_hi_q, res_lo_q};

    // Start source select
    always_comb begin
        src_ev = 1'b0;
        if (src[`ADCC_CTL_SRC_HI]) begin
            src_ev = external_convert_strobe && !strobe_q;
        end else begin
            unique case (src)
                `ADCC_SRC_SW: src_ev = wr_ctl && sfr_wdata[`ADCC_CTL_BUSY];
                `ADCC_SRC_T0: src_ev = timer0_overflow;
                `ADCC_SRC_T2: src_ev = timer2_overflow;
                `ADCC_SRC_T3: src_ev = timer3_overflow;
                default:      src_ev = 1'b0;
            endcase
        end
    end

    // Shutdown blocks starts; in burst the converter wakes itself per start
    assign start = src_ev && (enable || burst) && (st_q == adcc_pkg::st_idle);

    adcc_sar_div u_div (
        .clock    (clock),
        .rst      (rst),
        .src_tick (burst ? lp_osc_tick : 1'b1),
        .restart  (start),
        .divide   (cfg_q[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO]),
        .sar_tick (sar_tick)
    );

    // Conversion sequencer
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        left_d   = left_q;
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        unique case (st_q)
            adcc_pkg::st_idle: begin
                if (start) begin
                    left_d = burst ? rpt : `ADCC_RPT_ONE;
                    if (dtrack) begin
                        st_d  = adcc_pkg::st_track;
                        cnt_d = `ADCC_TRACK_CLKS;
                    end else begin
                        st_d  = adcc_pkg::st_conv;
                        cnt_d = conv_len;
                    end
                end
            end
            adcc_pkg::st_track: begin
                if (sar_tick) begin
                    if (cnt_q == `ADCC_CNT_ONE) begin
                        st_d  = adcc_pkg::st_conv;
                        cnt_d = conv_len;
                    end else begin
                        cnt_d = cnt_q - `ADCC_CNT_ONE;
                    end
                end
            end
            adcc_pkg::st_conv: begin
                if (sar_tick) begin
                    if (cnt_q == `ADCC_CNT_ONE) begin
                        if (eight) begin
                            res_hi_d = sample_data[9:2];
                            res_lo_d = 8'h00;
                        end else begin
                            res_hi_d = {6'h00, sample_data[9:8]};
                            res_lo_d = sample_data[7:0];
                        end
                        left_d = left_q - `ADCC_RPT_ONE;
                        if (left_q == `ADCC_RPT_ONE) begin
                            st_d = adcc_pkg::st_fin;
                        end else if (dtrack) begin
                            st_d  = adcc_pkg::st_track;
                            cnt_d = `ADCC_TRACK_CLKS;
                        end else begin
                            cnt_d = conv_len;
                        end
                    end else begin
                        cnt_d = cnt_q - `ADCC_CNT_ONE;
                    end
                end
            end
            adcc_pkg::st_fin: begin
                st_d = adcc_pkg::st_idle;
            end
        endcase
    end

    assign fin = (st_q == adcc_pkg::st_fin);
    // Inclusive bounds; compared once per completed conversion or burst
    assign in_window = (result >= lower_threshold) && (result <= upper_threshold);

    // Register writes; hardware sets win over a software clear in the same cycle
    always_comb begin
        ctl_d = ctl_q;
        cfg_d = cfg_q;
        if (wr_ctl) begin
            ctl_d = sfr_wdata;
            ctl_d[`ADCC_CTL_BUSY] = 1'b0;
        end
        if (wr_cfg) begin
            cfg_d = sfr_wdata;
        end
        if (fin) begin
            ctl_d[`ADCC_CTL_DONE] = 1'b1;
            if (in_window) begin
                ctl_d[`ADCC_CTL_WIN] = 1'b1;
            end
        end
    end

    // Busy reads from the sequencer, not from storage
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd_en) begin
            unique case (sfr_addr)
                `ADCC_ADDR_CTL: begin
                    rdata_d = ctl_q;
                    rdata_d[`ADCC_CTL_BUSY] = (st_q != adcc_pkg::st_idle);
                end
                `ADCC_ADDR_CFG: rdata_d = cfg_q;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_q    <= `ADCC_CTL_RESET;
            cfg_q    <= `ADCC_CFG_RESET;
            rdata_q  <= 8'h00;
            st_q     <= adcc_pkg::st_idle;
            cnt_q    <= 4'h0;
            left_q   <= 7'h00;
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
            strobe_q <= 1'b0;
        end else begin
            ctl_q    <= ctl_d;
            cfg_q    <= cfg_d;
            rdata_q  <= rdata_d;
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            left_q   <= left_d;
            res_hi_q <= res_hi_d;
            res_lo_q <= res_lo_d;
            strobe_q <= external_convert_strobe;
        end
    end

    assign sfr_rdata         = rdata_q;
    assign converter_powered = enable || (st_q != adcc_pkg::st_idle);
    assign tracking          = (st_q == adcc_pkg::st_track);
    assign converting        = (st_q == adcc_pkg::st_conv);
    assign gain_select       = cfg_q[`ADCC_CFG_GAIN];
    assign eight_bit_mode    = eight;
    assign result_high       = res_hi_q;
    assign result_low        = res_lo_q;

    // Helpers for the checks below
    logic [5:0] gap_q;
    logic [6:0] conv_seen_q;
    logic       rate_ok_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_q       <= 6'h00;
            conv_seen_q <= 7'h00;
            rate_ok_q   <= 1'b0;
        end else begin
            gap_q <= (sar_tick || start) ? 6'h00 : gap_q + 6'h01;
            // A period that straddles a divider or mode change is not a fair sample
            if (wr_cfg || wr_ctl) begin
                rate_ok_q <= 1'b0;
            end else if (sar_tick) begin
                rate_ok_q <= 1'b1;
            end
            if (start) begin
                conv_seen_q <= 7'h00;
            end else if (converting && sar_tick && (cnt_q == `ADCC_CNT_ONE)) begin
                conv_seen_q <= conv_seen_q + 7'h01;
            end
        end
    end

    property p_shutdown_blocks;
        @(posedge clock) disable iff (rst)
        (st_q == adcc_pkg::st_idle) && !enable && !burst |=> (st_q == adcc_pkg::st_idle);
    endproperty
    a_shutdown_blocks: assert property (p_shutdown_blocks)
        else $error("conversion began while shut down");

    property p_burst_count;
        @(posedge clock) disable iff (rst)
        fin && burst |-> (conv_seen_q == rpt);
    endproperty
    a_burst_count: assert property (p_burst_count)
        else $error("burst ended with wrong conversion count");

    property p_done_set;
        @(posedge clock) disable iff (rst)
        fin |=> ctl_q[`ADCC_CTL_DONE] && (st_q == adcc_pkg::st_idle);
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set after conversion");

    property p_window_set;
        @(posedge clock) disable iff (rst)
        fin && in_window |=> ctl_q[`ADCC_CTL_WIN];
    endproperty
    a_window_set: assert property (p_window_set)
        else $error("window flag not set");

    property p_flags_sticky;
        @(posedge clock) disable iff (rst)
        ctl_q[`ADCC_CTL_DONE] && !wr_ctl |=> ctl_q[`ADCC_CTL_DONE];
    endproperty
    a_flags_sticky: assert property (p_flags_sticky)
        else $error("done flag cleared without a write");

    property p_sw_start;
        @(posedge clock) disable iff (rst)
        wr_ctl && sfr_wdata[`ADCC_CTL_BUSY] && (src == `ADCC_SRC_SW) && enable
        && (st_q == adcc_pkg::st_idle) |=> (st_q != adcc_pkg::st_idle);
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start ignored");

    property p_strobe_start;
        @(posedge clock) disable iff (rst)
        src[`ADCC_CTL_SRC_HI] && enable && (st_q == adcc_pkg::st_idle)
        && $rose(external_convert_strobe) |=> (st_q != adcc_pkg::st_idle);
    endproperty
    a_strobe_start: assert property (p_strobe_start)
        else $error("strobe edge did not start");

    property p_sar_rate;
        @(posedge clock) disable iff (rst)
        sar_tick && !burst && rate_ok_q && !$past(start) && ($past(gap_q) != 6'h00)
        |-> (gap_q == {1'b0, cfg_q[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO]});
    endproperty
    a_sar_rate: assert property (p_sar_rate)
        else $error("SAR clock period wrong");

    property p_delayed_track;
        @(posedge clock) disable iff (rst)
        start && dtrack |=> tracking [*1] ##0 (cnt_q == `ADCC_TRACK_CLKS);
    endproperty
    a_delayed_track: assert property (p_delayed_track)
        else $error("delayed track not entered");

    property p_eight_low_zero;
        @(posedge clock) disable iff (rst)
        converting && eight && sar_tick && (cnt_q == `ADCC_CNT_ONE) |=> (result_low == 8'h00);
    endproperty
    a_eight_low_zero: assert property (p_eight_low_zero)
        else $error("low byte not zero in eight-bit mode");
endmodule

//--- verif/test_adc_conversion_control.sv
`timescale 1ns/1ps
module test_adc_conversion_control;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr_en = 1'b0;
    logic        sfr_rd_en = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    logic        timer0_overflow = 1'b0;
    logic        timer2_overflow = 1'b0;
    logic        timer3_overflow = 1'b0;
    logic        external_convert_strobe = 1'b0;
    logic        lp_osc_tick = 1'b0;
    logic [9:0]  sample_data = 10'h2b5;
    logic [6:0]  burst_repeat = 7'h02;
    logic [15:0] upper_threshold = 16'h02ff;
    logic [15:0] lower_threshold = 16'h0200;
    logic        converter_powered;
    logic        tracking;
    logic        converting;
    logic        gain_select;
    logic        eight_bit_mode;
    logic [7:0]  result_high;
    logic [7:0]  result_low;
    logic        lp_on = 1'b0;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          trk;
    int          cnv;
    logic [7:0]  rv;

    adcc_top dut (
        .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .timer0_overflow(timer0_overflow), .timer2_overflow(timer2_overflow),
        .timer3_overflow(timer3_overflow), .external_convert_strobe(external_convert_strobe),
        .lp_osc_tick(lp_osc_tick), .sample_data(sample_data), .burst_repeat(burst_repeat),
        .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
        .converter_powered(converter_powered), .tracking(tracking),
        .converting(converting), .gain_select(gain_select),
        .eight_bit_mode(eight_bit_mode), .result_high(result_high), .result_low(result_low)
    );

    always #10 clock = ~clock;

    // Oscillator stand-in ticks every other system clock while enabled
    always @(negedge clock) lp_osc_tick <= lp_on & ~lp_osc_tick;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task end_of_test;
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_n(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(negedge clock);
        sfr_wr_en = 1'b0;
    endtask

    // Read data is registered, so it is settled at the following falling edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        @(negedge clock);
        sfr_rd_en = 1'b0;
        d = sfr_rdata;
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk8(d, exp);
    endtask

    task pulse(input logic [3:0] m);
        @(negedge clock);
        timer0_overflow = m[0];
        timer2_overflow = m[1];
        timer3_overflow = m[2];
        external_convert_strobe = m[3];
        @(negedge clock);
        {timer0_overflow, timer2_overflow, timer3_overflow} = 3'h0;
        external_convert_strobe = 1'b0;
    endtask

    // Counts track and convert cycles until the sequencer falls quiet
    task run_count;
        int i;
        trk = 0;
        cnv = 0;
        for (i = 0; i < 2000; i++) begin
            if (tracking === 1'b1) trk++;
            if (converting === 1'b1) cnv++;
            if (trk + cnv > 0 && tracking !== 1'b1 && converting !== 1'b1) break;
            @(negedge clock);
        end
        repeat (2) @(negedge clock);
    endtask

    task t_reset;
        rchk(8'he8, 8'h00);
        rchk(8'hbc, 8'hf8);
        wr(8'h10, 8'hff);
        rchk(8'h10, 8'h00);
        chk8({7'h00, converter_powered}, 8'h00);
    endtask

    task t_sw;
        wr(8'hbc, 8'h00);
        chk8({6'h00, gain_select, eight_bit_mode}, 8'h00);
        wr(8'he8, 8'h80);
        chk8({7'h00, converter_powered}, 8'h01);
        wr(8'he8, 8'h90);
        run_count();
        chk_n(cnv, 10);
        chk_n(trk, 0);
        rchk(8'he8, 8'ha8);
        chk8(result_high, 8'h02);
        chk8(result_low, 8'hb5);
        repeat (20) @(negedge clock);
        rchk(8'he8, 8'ha8);
        wr(8'he8, 8'h80);
        rchk(8'he8, 8'h80);
    endtask

    task t_refuse;
        wr(8'he8, 8'h81);
        wr(8'he8, 8'h91);
        repeat (4) @(negedge clock);
        chk8({7'h00, converting}, 8'h00);
        rchk(8'he8, 8'h81);
        wr(8'he8, 8'h00);
        chk8({7'h00, converter_powered}, 8'h00);
        wr(8'he8, 8'h10);
        repeat (4) @(negedge clock);
        rchk(8'he8, 8'h00);
    endtask

    task t_sources;
        int c;
        logic [3:0] m;
        for (c = 1; c < 8; c++) begin
            m = (c >= 4) ? 4'h8 : 4'(1 << (c - 1));
            wr(8'he8, 8'h80 | 8'(c));
            pulse(~m);
            repeat (3) @(negedge clock);
            chk8({7'h00, converting}, 8'h00);
            pulse(m);
            rchk(8'he8, 8'h90 | 8'(c));
            run_count();
            rchk(8'he8, 8'ha8 | 8'(c));
        end
    endtask

    task t_track;
        wr(8'hbc, 8'h12);
        wr(8'he8, 8'h80);
        wr(8'he8, 8'h90);
        run_count();
        chk_n(trk, 9);
        chk_n(cnv, 30);
        wr(8'he8, 8'h80);
        wr(8'hbc, 8'h07);
        chk8({6'h00, gain_select, eight_bit_mode}, 8'h03);
        wr(8'he8, 8'h90);
        run_count();
        chk_n(trk, 3);
        chk_n(cnv, 8);
        chk8(result_high, 8'had);
        chk8(result_low, 8'h00);
        rchk(8'he8, 8'ha0);
    endtask

    // Without oscillator ticks a burst must not advance on the system clock
    task t_burst;
        int i;
        wr(8'hbc, 8'h00);
        wr(8'he8, 8'h40);
        wr(8'he8, 8'h50);
        repeat (30) @(negedge clock);
        rchk(8'he8, 8'h50);
        chk8({7'h00, converter_powered}, 8'h01);
        lp_on = 1'b1;
        for (i = 0; i < 300; i++) begin
            rd(8'he8, rv);
            if (rv[5] === 1'b1) break;
        end
        chk8(rv, 8'h68);
        repeat (4) @(negedge clock);
        chk8({7'h00, converter_powered}, 8'h00);
        lp_on = 1'b0;
    endtask

    initial begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_sw();
        t_refuse();
        t_sources();
        t_track();
        t_burst();
        end_of_test();
    end
endmodule
